// ==== rtl/rsg_ringing_generator.sv ====
//----------------------------------------------------------------------
// Ringing signal generator
//----------------------------------------------------------------------
// Purpose: Sine/trapezoid ringing waveform with hardware cadence.
// Assumes: Register port driven from logic on ref_clk_i.
// Notes:   Reads answer one cycle later with rd_valid_o.
//----------------------------------------------------------------------
`timescale 1ns/1ps

module rsg_ringing_generator #(
    parameter int STEP_CYCLES = rsg_pkg::STEP_CYCLES
) (
    input  wire logic              ref_clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              ce_i,
    input  wire rsg_pkg::rsg_req_t req_i,
    output logic [7:0]             rd_data_o,
    output logic                   rd_valid_o,
    output rsg_pkg::rsg_line_t     line_o
);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        cfg;
        logic [15:0]       on_time;
        logic [15:0]       off_time;
        logic [2:0]        line_field;
        logic [5:0]        high_supply;
        logic [15:0]       ind_data;
        logic [15:0]       dc_offset;
        logic [15:0]       freq_coeff;
        logic [15:0]       ampl_coeff;
        logic [15:0]       phase_period;
        logic [3:0]        cm_adjust;
        rsg_pkg::rsg_cad_t cad;
        logic [15:0]       step_cnt;
        logic [2:0]        sub_cnt;
        logic [15:0]       timer;
        logic [15:0]       y1;
        logic [15:0]       y2;
        logic              ramp_down;
        logic [15:0]       half_cnt;
        logic [15:0]       sample;
        logic              sample_vld;
        logic [2:0]        line_shadow;
        logic [7:0]        rd_data;
        logic              rd_valid;
    } rsg_state_t;

    rsg_state_t st_ff;
    rsg_state_t nxt_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Saturating signed add keeps the line drive from wrapping sign
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        if (s[16] != s[15])
        begin
            sat_add = s[16] ? 16'h8000 : 16'h7FFF;
        end
        else
        begin
            sat_add = s[15:0];
        end
    endfunction

    // Resonator step: 2*c*y1 - y2 with c in Q15
    function automatic logic [15:0] osc_step(input logic [15:0] c, input logic [15:0] y1,
                                             input logic [15:0] y2);
        logic signed [31:0] prod;
        logic signed [17:0] acc;
        prod = $signed(c) * $signed(y1);
        acc  = $signed(prod[31:14]) - $signed({{2{y2[15]}}, y2});
        osc_step = acc[15:0];
    endfunction

    logic        step_tick;
    logic        sample_tick;
    logic        osc_on;
    logic        trap_mode;
    logic [15:0] trap_next;
    logic [15:0] wave_raw;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_st      = st_ff;
        step_tick   = (st_ff.step_cnt == 16'(STEP_CYCLES - 1));
        sample_tick = step_tick && (st_ff.sub_cnt == rsg_pkg::STEPS_PER_SAMPLE_M1);
        trap_mode   = st_ff.cfg[rsg_pkg::CFG_SHAPE_BIT];
        osc_on      = st_ff.cfg[rsg_pkg::CFG_OSC_EN_BIT];
        trap_next   = 16'h0000;
        wave_raw    = 16'h0000;
        nxt_st.sample_vld = 1'b0;
        nxt_st.rd_valid   = 1'b0;

        // Free-running 8 kHz step and 1 kHz sample dividers
        nxt_st.step_cnt = step_tick ? 16'h0000 : st_ff.step_cnt + 16'h0001;
        if (step_tick)
        begin
            nxt_st.sub_cnt = st_ff.sub_cnt + 3'h1;
        end

        // Register writes; indirect space only through the access window
        if (req_i.wr)
        begin
            case (req_i.addr)
                rsg_pkg::ADDR_IND_DATA_LO: nxt_st.ind_data[7:0]  = req_i.wdata;
                rsg_pkg::ADDR_IND_DATA_HI: nxt_st.ind_data[15:8] = req_i.wdata;
                rsg_pkg::ADDR_IND_WR_ADDR:
                begin
                    case (req_i.wdata)
                        rsg_pkg::IND_RING_DC_OFFSET: nxt_st.dc_offset    = st_ff.ind_data;
                        rsg_pkg::IND_RING_FREQ:      nxt_st.freq_coeff   = st_ff.ind_data;
                        rsg_pkg::IND_RING_AMPL:      nxt_st.ampl_coeff   = st_ff.ind_data;
                        rsg_pkg::IND_RING_PHASE:     nxt_st.phase_period = st_ff.ind_data;
                        rsg_pkg::IND_RING_CM:        nxt_st.cm_adjust    = st_ff.ind_data[3:0];
                        default:                     nxt_st.ind_data     = st_ff.ind_data;
                    endcase
                end
                rsg_pkg::ADDR_IND_RD_ADDR:
                begin
                    case (req_i.wdata)
                        rsg_pkg::IND_RING_DC_OFFSET: nxt_st.ind_data = st_ff.dc_offset;
                        rsg_pkg::IND_RING_FREQ:      nxt_st.ind_data = st_ff.freq_coeff;
                        rsg_pkg::IND_RING_AMPL:      nxt_st.ind_data = st_ff.ampl_coeff;
                        rsg_pkg::IND_RING_PHASE:     nxt_st.ind_data = st_ff.phase_period;
                        rsg_pkg::IND_RING_CM:        nxt_st.ind_data = {12'h000, st_ff.cm_adjust};
                        default:                     nxt_st.ind_data = rsg_pkg::RST_WORD;
                    endcase
                end
                rsg_pkg::ADDR_RING_CONFIG: nxt_st.cfg            = {3'h0, req_i.wdata[4:0]};
                rsg_pkg::ADDR_ON_TIME_LO:  nxt_st.on_time[7:0]   = req_i.wdata;
                rsg_pkg::ADDR_ON_TIME_HI:  nxt_st.on_time[15:8]  = req_i.wdata;
                rsg_pkg::ADDR_OFF_TIME_LO: nxt_st.off_time[7:0]  = req_i.wdata;
                rsg_pkg::ADDR_OFF_TIME_HI: nxt_st.off_time[15:8] = req_i.wdata;
                rsg_pkg::ADDR_LINE_STATE:  nxt_st.line_field     = req_i.wdata[2:0];
                rsg_pkg::ADDR_HIGH_SUPPLY: nxt_st.high_supply    = req_i.wdata[5:0];
                default:                   nxt_st.rd_valid       = 1'b0;
            endcase
        end

        // Register reads, answered next cycle; unmapped reads give zero
        if (req_i.rd)
        begin
            nxt_st.rd_valid = 1'b1;
            case (req_i.addr)
                rsg_pkg::ADDR_IND_DATA_LO: nxt_st.rd_data = st_ff.ind_data[7:0];
                rsg_pkg::ADDR_IND_DATA_HI: nxt_st.rd_data = st_ff.ind_data[15:8];
                rsg_pkg::ADDR_RING_CONFIG: nxt_st.rd_data = st_ff.cfg;
                rsg_pkg::ADDR_ON_TIME_LO:  nxt_st.rd_data = st_ff.on_time[7:0];
                rsg_pkg::ADDR_ON_TIME_HI:  nxt_st.rd_data = st_ff.on_time[15:8];
                rsg_pkg::ADDR_OFF_TIME_LO: nxt_st.rd_data = st_ff.off_time[7:0];
                rsg_pkg::ADDR_OFF_TIME_HI: nxt_st.rd_data = st_ff.off_time[15:8];
                rsg_pkg::ADDR_LINE_STATE:  nxt_st.rd_data = {5'h00, st_ff.line_field};
                rsg_pkg::ADDR_HIGH_SUPPLY: nxt_st.rd_data = {2'h0, st_ff.high_supply};
                default:                   nxt_st.rd_data = rsg_pkg::RST_BYTE;
            endcase
        end

        // --------------------------------------------------------------
        // Cadence: software write of a non-ringing code wins over the timer
        // --------------------------------------------------------------
        case (st_ff.cad)
            rsg_pkg::CAD_IDLE:
            begin
                if (st_ff.line_field == rsg_pkg::LINE_RINGING)
                begin
                    nxt_st.cad         = rsg_pkg::CAD_ON;
                    nxt_st.timer       = rsg_pkg::RST_WORD;
                    nxt_st.line_shadow = rsg_pkg::LINE_RINGING;
                    nxt_st.cfg[rsg_pkg::CFG_OSC_EN_BIT] = 1'b1;
                    nxt_st.y1          = st_ff.phase_period;
                    // Trapezoid ramps from zero; there the phase register is the half period
                    if (trap_mode)
                    begin
                        nxt_st.y1 = rsg_pkg::RST_WORD;
                    end
                    nxt_st.y2          = st_ff.ampl_coeff;
                    nxt_st.ramp_down   = 1'b0;
                    nxt_st.half_cnt    = rsg_pkg::RST_WORD;
                end
                else
                begin
                    nxt_st.line_shadow = st_ff.line_field;
                end
            end
            rsg_pkg::CAD_ON:
            begin
                if (st_ff.cfg[rsg_pkg::CFG_ON_TMR_BIT] && step_tick)
                begin
                    nxt_st.timer = st_ff.timer + 16'h0001;
                    if (st_ff.timer >= st_ff.on_time)
                    begin
                        nxt_st.timer       = rsg_pkg::RST_WORD;
                        nxt_st.cfg[rsg_pkg::CFG_OSC_EN_BIT] = 1'b0;
                        nxt_st.line_shadow = rsg_pkg::LINE_ONHOOK_TX;
                        nxt_st.cad         = rsg_pkg::CAD_OFF;
                    end
                end
            end
            rsg_pkg::CAD_OFF:
            begin
                // Without the off timer the ring stays a one-shot
                if (st_ff.cfg[rsg_pkg::CFG_OFF_TMR_BIT] && step_tick)
                begin
                    nxt_st.timer = st_ff.timer + 16'h0001;
                    if (st_ff.timer >= st_ff.off_time)
                    begin
                        nxt_st.timer       = rsg_pkg::RST_WORD;
                        nxt_st.cfg[rsg_pkg::CFG_OSC_EN_BIT] = 1'b1;
                        nxt_st.line_shadow = rsg_pkg::LINE_RINGING;
                        nxt_st.cad         = rsg_pkg::CAD_ON;
                        nxt_st.y1          = st_ff.phase_period;
                        // Each new ring of a trapezoid starts from zero again
                        if (trap_mode)
                        begin
                            nxt_st.y1 = rsg_pkg::RST_WORD;
                        end
                        nxt_st.y2          = st_ff.ampl_coeff;
                        nxt_st.ramp_down   = 1'b0;
                        nxt_st.half_cnt    = rsg_pkg::RST_WORD;
                    end
                end
            end
            default:
            begin
                nxt_st.cad = rsg_pkg::CAD_IDLE;
            end
        endcase

        // Leaving the ringing code ends the cadence at once
        if (st_ff.cad != rsg_pkg::CAD_IDLE && st_ff.line_field != rsg_pkg::LINE_RINGING)
        begin
            nxt_st.cad         = rsg_pkg::CAD_IDLE;
            nxt_st.line_shadow = st_ff.line_field;
            nxt_st.cfg[rsg_pkg::CFG_OSC_EN_BIT] = 1'b0;
        end

        // --------------------------------------------------------------
        // Waveform engines
        // --------------------------------------------------------------
        trap_next = st_ff.ramp_down ? sat_add(st_ff.y1, -st_ff.freq_coeff)
                                    : sat_add(st_ff.y1, st_ff.freq_coeff);
        if (osc_on && !trap_mode && sample_tick)
        begin
            nxt_st.y1 = osc_step(st_ff.freq_coeff, st_ff.y1, st_ff.y2);
            nxt_st.y2 = st_ff.y1;
            wave_raw  = nxt_st.y1;
            nxt_st.sample_vld = 1'b1;
        end
        else if (osc_on && trap_mode && step_tick)
        begin
            // Ramp clamps at the programmed crest, phase register is half period
            if (!st_ff.ramp_down && $signed(trap_next) > $signed(st_ff.ampl_coeff))
            begin
                trap_next = st_ff.ampl_coeff;
            end
            else if (st_ff.ramp_down && $signed(trap_next) < -$signed(st_ff.ampl_coeff))
            begin
                trap_next = -st_ff.ampl_coeff;
            end
            nxt_st.y1       = trap_next;
            nxt_st.half_cnt = st_ff.half_cnt + 16'h0001;
            if (st_ff.half_cnt + 16'h0001 >= st_ff.phase_period)
            begin
                nxt_st.half_cnt  = rsg_pkg::RST_WORD;
                nxt_st.ramp_down = !st_ff.ramp_down;
            end
            wave_raw = trap_next;
            nxt_st.sample_vld = 1'b1;
        end

        // Offset only when enabled; a stopped oscillator drives zero
        if (nxt_st.sample_vld)
        begin
            nxt_st.sample = st_ff.cfg[rsg_pkg::CFG_OFFSET_EN_BIT]
                          ? sat_add(wave_raw, st_ff.dc_offset) : wave_raw;
        end
        else if (!osc_on)
        begin
            nxt_st.sample = rsg_pkg::RST_WORD;
        end
    end

    // ------------------------------------------------------------------
    // State register, frozen while ce_i is low
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_ff <= '0;
        end
        else if (ce_i)
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rd_data_o          = st_ff.rd_data;
    assign rd_valid_o         = st_ff.rd_valid;
    assign line_o.sample      = st_ff.sample;
    assign line_o.sample_vld  = st_ff.sample_vld;
    assign line_o.line_state  = st_ff.line_shadow;
    assign line_o.cm_adjust   = st_ff.cm_adjust;
    assign line_o.high_supply = st_ff.high_supply;

endmodule // rsg_ringing_generator

// ==== rtl/rsg_pkg.sv ====
//----------------------------------------------------------------------
// Ringing signal generator package
//----------------------------------------------------------------------
// Purpose: Register map, field layout, timing counts and carriers.
// Assumes: 40 MHz ref_clk_i, 8-bit direct register port.
// Notes:   Indirect registers are 16 bits wide (IND_RING_CM keeps 4), reached through 28..31.
//----------------------------------------------------------------------
package rsg_pkg;

    // ------------------------------------------------------------------
    // Direct register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IND_DATA_LO   = 8'h1C;
    localparam logic [7:0] ADDR_IND_DATA_HI   = 8'h1D;
    localparam logic [7:0] ADDR_IND_WR_ADDR   = 8'h1E;
    localparam logic [7:0] ADDR_IND_RD_ADDR   = 8'h1F;
    localparam logic [7:0] ADDR_RING_CONFIG   = 8'h22;
    localparam logic [7:0] ADDR_ON_TIME_LO    = 8'h30;
    localparam logic [7:0] ADDR_ON_TIME_HI    = 8'h31;
    localparam logic [7:0] ADDR_OFF_TIME_LO   = 8'h32;
    localparam logic [7:0] ADDR_OFF_TIME_HI   = 8'h33;
    localparam logic [7:0] ADDR_LINE_STATE    = 8'h40;
    localparam logic [7:0] ADDR_HIGH_SUPPLY   = 8'h4A;

    // ------------------------------------------------------------------
    // Indirect register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] IND_RING_DC_OFFSET = 8'h13;
    localparam logic [7:0] IND_RING_FREQ      = 8'h14;
    localparam logic [7:0] IND_RING_AMPL      = 8'h15;
    localparam logic [7:0] IND_RING_PHASE     = 8'h16;
    localparam logic [7:0] IND_RING_CM        = 8'h28;

    // ------------------------------------------------------------------
    // Config bit positions, line states, reset values
    // ------------------------------------------------------------------
    localparam int         CFG_SHAPE_BIT      = 0;
    localparam int         CFG_OFFSET_EN_BIT  = 1;
    localparam int         CFG_OSC_EN_BIT     = 2;
    localparam int         CFG_OFF_TMR_BIT    = 3;
    localparam int         CFG_ON_TMR_BIT     = 4;
    localparam logic [2:0] LINE_RINGING       = 3'h4;
    localparam logic [2:0] LINE_ONHOOK_TX     = 3'h2;
    localparam logic [7:0] RST_BYTE           = 8'h00;
    localparam logic [15:0] RST_WORD          = 16'h0000;

    // ------------------------------------------------------------------
    // Timing: 8 kHz timer step, sine ring samples every 8th step (1 kHz)
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_PS      = 25000;
    localparam int         STEP_PERIOD_NS     = 125000;
    localparam int         STEP_CYCLES        = (STEP_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [2:0] STEPS_PER_SAMPLE_M1 = 3'h7;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsg_req_t;

    // Waveform sample and line state towards the linefeed driver
    typedef struct packed {
        logic [15:0] sample;
        logic        sample_vld;
        logic [2:0]  line_state;
        logic [3:0]  cm_adjust;
        logic [5:0]  high_supply;
    } rsg_line_t;

    typedef enum logic [1:0] {CAD_IDLE, CAD_ON, CAD_OFF} rsg_cad_t;

endpackage

// ==== test/rsg_checker.sv ====
// Purpose: Port assertions for the ringing generator
// Assumes: One clock domain, ce_i high in checked traffic
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module rsg_checker #(
    parameter int STEP_CYCLES = 4
) (
    input wire logic               ref_clk_i,
    input wire logic               arst_n_i,
    input wire logic               ce_i,
    input wire rsg_pkg::rsg_req_t  req_i,
    input wire logic [7:0]         rd_data_o,
    input wire logic               rd_valid_o,
    input wire rsg_pkg::rsg_line_t line_o
);
    // ----------------
    // Helpers
    // ----------------
    logic        rd_take;
    logic        lf_wr;
    logic        mapped;
    logic [15:0] gap_ff;
    assign rd_take = req_i.rd & ce_i;
    assign lf_wr   = req_i.wr & ce_i & (req_i.addr == 8'h40);
    assign mapped  = req_i.addr inside {[8'h1C:8'h1F], 8'h22, [8'h30:8'h33], 8'h40, 8'h4A};
    // Saturates, so a long idle never wraps into a short gap
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            gap_ff <= 16'hFFFF;
        else if (line_o.sample_vld)
            gap_ff <= 16'h0001;
        else if (gap_ff != 16'hFFFF)
            gap_ff <= gap_ff + 16'h0001;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    AST_RD_ANSWER: assert property (rd_take |=> rd_valid_o)
        else $error("read not answered");
    AST_RD_CAUSE: assert property (rd_valid_o |-> $past(rd_take))
        else $error("read answer without request");
    AST_UNMAPPED: assert property (rd_take && !mapped |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    AST_CFG_RSVD: assert property (
        rd_take && req_i.addr == 8'h22 |=> rd_data_o[7:5] == 3'h0)
        else $error("config spare bits not zero");
    AST_DATA_HOLD: assert property (!rd_valid_o |-> $stable(rd_data_o))
        else $error("read data moved without read");
    AST_RING_START: assert property (
        lf_wr && req_i.wdata[2:0] == 3'h4 && line_o.line_state == 3'h0
        |-> ##2 line_o.line_state == 3'h4)
        else $error("ringing not entered");
    AST_STOP: assert property (
        lf_wr && req_i.wdata[2:0] == 3'h0 |-> ##2 line_o.line_state == 3'h0)
        else $error("line state did not follow field");
    AST_SILENT: assert property (
        $past(line_o.line_state) == 3'h4 && line_o.line_state == 3'h2
        |-> ##[0:2] line_o.sample == 16'h0000)
        else $error("waveform not stopped");
    AST_VLD_PULSE: assert property (line_o.sample_vld && ce_i |=> !line_o.sample_vld)
        else $error("sample strobe too long");
    AST_VLD_GAP: assert property (
        line_o.sample_vld && $past(ce_i) |-> gap_ff >= 16'(STEP_CYCLES))
        else $error("samples closer than one step");
endmodule // rsg_checker

bind rsg_ringing_generator rsg_checker #(
    .STEP_CYCLES(STEP_CYCLES)
) rsg_checker_inst (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .req_i      (req_i),
    .rd_data_o  (rd_data_o),
    .rd_valid_o (rd_valid_o),
    .line_o     (line_o)
);

// ==== test/rsg_line_model.sv ====
// Purpose: Linefeed driver model that receives ringing samples
// Assumes: Offset disabled while the sine check runs
// Notes:   First samples after a reseed are only recorded
`timescale 1ns/1ps
module rsg_line_model (
    input wire logic               ref_clk_i,
    input wire logic               arst_n_i,
    input wire rsg_pkg::rsg_line_t line_i,
    input wire logic [15:0]        coeff_i,
    input wire logic               sine_i,
    output logic [15:0]            gap_o,
    output logic [15:0]            err_o
);
    // ----------------
    // Sample history
    // ----------------
    logic [15:0]        y1_ff;
    logic [15:0]        y2_ff;
    logic [15:0]        run_ff;
    logic [1:0]         seen_ff;
    logic signed [31:0] prod;
    logic [15:0]        pred;
    assign prod = $signed(coeff_i) * $signed(y1_ff);
    assign pred = 16'(prod >>> 14) - y2_ff;
    // History restarts whenever the line leaves ringing
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            {y1_ff, y2_ff, run_ff, seen_ff, gap_o, err_o} <= '0;
        else
        begin
            run_ff <= line_i.sample_vld ? 16'h0001 : run_ff + 16'h0001;
            if (line_i.sample_vld && line_i.line_state == rsg_pkg::LINE_RINGING)
            begin
                gap_o <= run_ff;
                y1_ff <= line_i.sample;
                y2_ff <= y1_ff;
                seen_ff <= (seen_ff == 2'h3) ? seen_ff : seen_ff + 2'h1;
                if (sine_i && seen_ff == 2'h3 && line_i.sample !== pred)
                    err_o <= err_o + 16'h0001;
            end
            else if (line_i.line_state != rsg_pkg::LINE_RINGING)
                seen_ff <= 2'h0;
        end
    end
endmodule // rsg_line_model

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the ringing generator
// Assumes: Step shortened to 4 clock cycles
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
    // ----------------
    // Signals
    // ----------------
    logic               ref_clk_i = 1'b0;
    logic               arst_n_i = 1'b0;
    logic               ce_i = 1'b1;
    rsg_pkg::rsg_req_t  req_i = '0;
    logic [7:0]         rd_data_o;
    logic               rd_valid_o;
    rsg_pkg::rsg_line_t line_o;
    logic [15:0]        coeff = 16'h0000;
    logic               sine_mode = 1'b0;
    logic [15:0]        gap;
    logic [15:0]        err;
    int                 fail_count = 0;
    int                 samples_checked = 0;
    int                 cycles = 0;
    int                 n;
    always #12.5 ref_clk_i = ~ref_clk_i;
    rsg_ringing_generator #(.STEP_CYCLES(4)) rsg_ringing_generator_inst (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .req_i(req_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .line_o(line_o));
    rsg_line_model rsg_line_model_inst (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .line_i(line_o),
        .coeff_i(coeff), .sine_i(sine_mode), .gap_o(gap), .err_o(err));
    // Whole run needs about 850 cycles
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        req_i = '{1'b1, 1'b0, a, d};
        @(negedge ref_clk_i);
        req_i = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk_i);
        req_i = '{1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk_i);
        chk({7'h00, rd_valid_o, rd_data_o}, {8'h01, e});
        req_i = '0;
    endtask
    // Steps to the k-th next sample strobe; the timeout guards a silent line
    task automatic next_sample(input int k);
        repeat (k)
        begin
            @(negedge ref_clk_i);
            while (line_o.sample_vld !== 1'b1) @(negedge ref_clk_i);
        end
    endtask
    task automatic iw(input logic [7:0] a, input logic [15:0] d);
        wr(8'h1C, d[7:0]);
        wr(8'h1D, d[15:8]);
        wr(8'h1E, a);
    endtask
    task automatic ir(input logic [7:0] a, input logic [15:0] e);
        wr(8'h1F, a);
        rd(8'h1C, e[7:0]);
        rd(8'h1D, e[15:8]);
    endtask
    task automatic wait_state(input logic [2:0] s, input int lim, output int k);
        k = 0;
        while (line_o.line_state !== s && k < lim)
        begin
            @(negedge ref_clk_i);
            k++;
        end
        chk({13'h0000, line_o.line_state}, {13'h0000, s});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic test_regs;
        rd(8'h22, rsg_pkg::RST_BYTE);
        wr(8'h22, 8'hE3);
        rd(8'h22, 8'h03);
        wr(8'h22, 8'h00);
        wr(8'h30, 8'h34);
        wr(8'h31, 8'h12);
        rd(8'h31, 8'h12);
        rd(8'h30, 8'h34);
        wr(8'h01, 8'hFF);
        rd(8'h01, 8'h00);
        wr(8'h4A, 8'h3F);
        chk({10'h000, line_o.high_supply}, 16'h003F);
        iw(8'h28, 16'h000F);
        ir(8'h28, 16'h000F);
        chk({12'h000, line_o.cm_adjust}, 16'h000F);
        ir(8'h99, 16'h0000);
        $display("test_regs done");
    endtask
    task automatic test_sine;
        coeff = 16'h7EFD;
        sine_mode = 1'b1;
        iw(8'h14, 16'h7EFD);
        iw(8'h15, 16'h0177);
        iw(8'h16, 16'h0000);
        iw(8'h13, 16'h0000);
        wr(8'h30, 8'h3C);
        wr(8'h31, 8'h00);
        wr(8'h32, 8'h14);
        wr(8'h33, 8'h00);
        wr(8'h22, 8'h18); // Sine, both timers, offset off
        wr(8'h40, 8'h04);
        repeat (2) @(negedge ref_clk_i);
        chk({13'h0000, line_o.line_state}, 16'h0004);
        rd(8'h22, 8'h1C);
        wait_state(3'h2, 400, n);
        repeat (2) @(negedge ref_clk_i);
        chk(line_o.sample, 16'h0000);
        chk(gap, 16'h0020);
        chk(err, 16'h0000);
        // Twenty frozen cycles stretch the off period by exactly twenty
        ce_i = 1'b0;
        repeat (20) @(negedge ref_clk_i);
        ce_i = 1'b1;
        wait_state(3'h4, 200, n);
        chk(16'(n + 22), 16'h0068);
        wait_state(3'h2, 400, n);
        chk(16'(n), 16'h00F4);
        $display("test_sine done");
    endtask
    task automatic test_trap;
        wr(8'h40, 8'h00);
        repeat (2) @(negedge ref_clk_i);
        chk({13'h0000, line_o.line_state}, 16'h0000);
        sine_mode = 1'b0;
        iw(8'h13, 16'h0040);
        iw(8'h14, 16'h0100);
        iw(8'h15, 16'h0800);
        iw(8'h16, 16'h0010);
        wr(8'h22, 8'h03);
        wr(8'h40, 8'h04);
        // Ramp of 0100 per step from zero, crest 0800, 16 steps a half, offset 0040
        next_sample(1);
        chk(line_o.sample, 16'h0140);
        next_sample(8);
        chk(line_o.sample, 16'h0840);
        next_sample(8);
        chk(line_o.sample, 16'h0740);
        next_sample(15);
        chk(line_o.sample, 16'hF840);
        chk({13'h0000, line_o.line_state}, 16'h0004);
        chk(gap, 16'h0004);
        wr(8'h40, 8'h00);
        $display("test_trap done");
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        test_regs();
        test_sine();
        test_trap();
        stop_test();
    end
endmodule // tb_top
